/* rtl/tam_monitor.v */
// Top: APB registers, four alerts and loop disconnection detection
`timescale 1ns/100ps
`default_nettype none
`include "tam_consts.vh"
module tam_monitor #(
  parameter DW = 16,
  parameter CW = 8,
  parameter TW = 16,
  parameter SAMPLE_DIV = `TAM_SAMPLE_DIV
) (
  input wire clk_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire signed [DW-1:0] process_value_i,
  input wire signed [DW-1:0] working_setpoint_i,
  input wire out_at_low_i,
  input wire out_at_high_i,
  output wire [3:0] alert_o,
  output wire loop_alert_o
);
  localparam [31:0] DIV_MAX = SAMPLE_DIV - 1;
  localparam [DW+1:0] LB_W_TEMP = `TAM_LB_WIDTH_TEMP;

  reg rst_s1_ff;
  reg rst_s2_ff;
  wire rst_n;

  reg [31:0] prdata_ff;
  reg pready_ff;
  reg pslverr_ff;

  reg op_mode_ff;
  reg op_rise_ff;
  reg [`TAM_CFG_W-1:0] cfg_ff;
  reg signed [DW-1:0] setv_ff;
  reg sv_change_ff;
  reg signed [DW-1:0] dband_ff;
  reg [CW-1:0] delay_ff;
  reg [15:0] modes_ff;
  reg signed [DW-1:0] asv_ff [0:3];
  reg [TW-1:0] lb_time_ff;
  reg [DW-1:0] span_ff;

  reg [31:0] div_ff;
  reg sample_ff;

  reg lb_active_ff;
  reg lb_low_ff;
  reg [TW-1:0] lb_cnt_ff;
  reg signed [DW+1:0] lb_ref_ff;
  reg loop_alert_ff;

  wire [3:0] alert_w;
  wire signed [DW+1:0] pv_x;
  wire signed [DW+1:0] dev_x;
  wire signed [DW+1:0] dband_x;
  wire rewait_ok;
  wire wr_en;
  wire setup;
  wire [31:0] status_word;
  wire [31:0] span_scaled;
  wire signed [DW+1:0] lb_width;
  wire lb_enable;
  wire lb_sat;
  wire expect_fall;
  wire lb_moved;
  reg [31:0] nxt_rdata;
  reg nxt_err;

  // Reset release through two flip-flops
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  assign rst_n = rst_s2_ff;

  // Sampling cycle enable
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= 32'h0000_0000;
      sample_ff <= 1'b0;
    end else if (div_ff >= DIV_MAX) begin
      div_ff <= 32'h0000_0000;
      sample_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 32'h0000_0001;
      sample_ff <= 1'b0;
    end
  end

  // Deviation against the working set value monitor
  assign pv_x = {{2{process_value_i[DW-1]}}, process_value_i};
  assign dev_x = pv_x - {{2{working_setpoint_i[DW-1]}}, working_setpoint_i};
  assign dband_x = {{2{dband_ff[DW-1]}}, dband_ff};

  // Limiter set, alone or with cascade slave, disables re-wait
  assign rewait_ok = ~cfg_ff[`TAM_CFG_LIMITER];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_alert
      // Alert n takes mode field n and set value n
      tam_alert_unit #(
        .DW(DW),
        .CW(CW)
      ) u_alert (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .sample_i(sample_ff),
        .op_mode_i(op_mode_ff),
        .op_rise_i(op_rise_ff),
        .sv_change_i(sv_change_ff),
        .rewait_ok_i(rewait_ok),
        .mode_i(modes_ff[gi*4 +: 4]),
        .pv_i(pv_x),
        .dev_i(dev_x),
        .asv_i({{2{asv_ff[gi][DW-1]}}, asv_ff[gi]}),
        .dband_i(dband_x),
        .delay_i(delay_ff),
        .alert_o(alert_w[gi])
      );
    end
  endgenerate

  assign alert_o = alert_w;

  // Loop disconnection judgment width
  assign span_scaled = ({{(32-DW){1'b0}}, span_ff} * `TAM_LB_SPAN_NUM) / `TAM_LB_SPAN_DEN;
  assign lb_width = cfg_ff[`TAM_CFG_INTTEMP] ? LB_W_TEMP : span_scaled[DW+1:0];

  assign lb_enable = op_mode_ff && (lb_time_ff != {TW{1'b0}})
    && !cfg_ff[`TAM_CFG_AUTOTUNE]
    && !cfg_ff[`TAM_CFG_HEATCOOL];
  assign lb_sat = out_at_low_i | out_at_high_i;

  // Reverse action expects a fall at minimum output
  assign expect_fall = cfg_ff[`TAM_CFG_REVERSE] ? lb_low_ff : ~lb_low_ff;
  assign lb_moved = expect_fall ? (lb_ref_ff - pv_x >= lb_width) : (pv_x - lb_ref_ff >= lb_width);

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lb_active_ff <= 1'b0;
      lb_low_ff <= 1'b0;
      lb_cnt_ff <= {TW{1'b0}};
      lb_ref_ff <= {(DW+2){1'b0}};
      loop_alert_ff <= 1'b0;
    end else if (!lb_enable) begin
      lb_active_ff <= 1'b0;
      lb_cnt_ff <= {TW{1'b0}};
      loop_alert_ff <= 1'b0;
    end else if (sample_ff) begin
      if (!lb_sat) begin
        lb_active_ff <= 1'b0;
        lb_cnt_ff <= {TW{1'b0}};
        loop_alert_ff <= 1'b0;
      end else if (!lb_active_ff || lb_low_ff != out_at_low_i) begin
        // Monitoring starts at saturation with a fresh reference
        lb_active_ff <= 1'b1;
        lb_low_ff <= out_at_low_i;
        lb_ref_ff <= pv_x;
        lb_cnt_ff <= {{(TW-1){1'b0}}, 1'b1};
      end else if (lb_cnt_ff >= lb_time_ff) begin
        // One judgment per judgment time
        loop_alert_ff <= ~lb_moved;
        lb_ref_ff <= pv_x;
        lb_cnt_ff <= {{(TW-1){1'b0}}, 1'b1};
      end else begin
        lb_cnt_ff <= lb_cnt_ff + {{(TW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign loop_alert_o = loop_alert_ff;

  assign status_word = {18'h00000, loop_alert_ff, 1'b0, alert_w, 8'h00};

  // APB: no wait states, write takes effect at the completing edge
  assign setup = psel_i & ~penable_i;
  assign wr_en = psel_i & penable_i & pready_ff & pwrite_i & ~pslverr_ff;

  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (paddr_i == `TAM_ADDR_CMD) begin
      nxt_rdata[`TAM_CMD_OPMODE] = op_mode_ff;
    end else if (paddr_i == `TAM_ADDR_CFG) begin
      nxt_rdata[`TAM_CFG_W-1:0] = cfg_ff;
    end else if (paddr_i == `TAM_ADDR_SETV) begin
      nxt_rdata[DW-1:0] = setv_ff;
    end else if (paddr_i == `TAM_ADDR_DBAND) begin
      nxt_rdata[DW-1:0] = dband_ff;
    end else if (paddr_i == `TAM_ADDR_DELAY) begin
      nxt_rdata[CW-1:0] = delay_ff;
    end else if (paddr_i == `TAM_ADDR_MODES) begin
      nxt_rdata[15:0] = modes_ff;
    end else if (paddr_i == `TAM_ADDR_ASV1) begin
      nxt_rdata[DW-1:0] = asv_ff[0];
    end else if (paddr_i == `TAM_ADDR_ASV2) begin
      nxt_rdata[DW-1:0] = asv_ff[1];
    end else if (paddr_i == `TAM_ADDR_ASV3) begin
      nxt_rdata[DW-1:0] = asv_ff[2];
    end else if (paddr_i == `TAM_ADDR_ASV4) begin
      nxt_rdata[DW-1:0] = asv_ff[3];
    end else if (paddr_i == `TAM_ADDR_LBTIME) begin
      nxt_rdata[TW-1:0] = lb_time_ff;
    end else if (paddr_i == `TAM_ADDR_SPAN) begin
      nxt_rdata[DW-1:0] = span_ff;
    end else if (paddr_i == `TAM_ADDR_STATUS) begin
      nxt_rdata = status_word;
      nxt_err = pwrite_i;
    end else if (paddr_i == `TAM_ADDR_WSP) begin
      nxt_rdata[DW-1:0] = working_setpoint_i;
      nxt_err = pwrite_i;
    end else if (paddr_i == `TAM_ADDR_PV) begin
      nxt_rdata[DW-1:0] = process_value_i;
      nxt_err = pwrite_i;
    end else begin
      nxt_err = 1'b1;
    end
  end

  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite_i ? 32'h0000_0000 : nxt_rdata;
      pready_ff <= 1'b1;
      pslverr_ff <= nxt_err;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  assign prdata_o = prdata_ff;
  assign pready_o = pready_ff;
  assign pslverr_o = pslverr_ff;

  // Register writes and command edge detection
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      op_mode_ff <= 1'b0;
      op_rise_ff <= 1'b0;
      cfg_ff <= `TAM_CFG_RST;
      setv_ff <= {DW{1'b0}};
      sv_change_ff <= 1'b0;
      dband_ff <= {DW{1'b0}};
      delay_ff <= {CW{1'b0}};
      modes_ff <= 16'h0000;
      asv_ff[0] <= {DW{1'b0}};
      asv_ff[1] <= {DW{1'b0}};
      asv_ff[2] <= {DW{1'b0}};
      asv_ff[3] <= {DW{1'b0}};
      lb_time_ff <= {TW{1'b0}};
      span_ff <= {DW{1'b0}};
    end else begin
      op_rise_ff <= 1'b0;
      sv_change_ff <= 1'b0;
      if (wr_en) begin
        if (paddr_i == `TAM_ADDR_CMD) begin
          op_mode_ff <= pwdata_i[`TAM_CMD_OPMODE];
          // Setting to operation transition
          op_rise_ff <= pwdata_i[`TAM_CMD_OPMODE] & ~op_mode_ff;
        end else if (paddr_i == `TAM_ADDR_CFG) begin
          cfg_ff <= pwdata_i[`TAM_CFG_W-1:0];
        end else if (paddr_i == `TAM_ADDR_SETV) begin
          setv_ff <= pwdata_i[DW-1:0];
          sv_change_ff <= pwdata_i[DW-1:0] != setv_ff;
        end else if (paddr_i == `TAM_ADDR_DBAND) begin
          dband_ff <= pwdata_i[DW-1:0];
        end else if (paddr_i == `TAM_ADDR_DELAY) begin
          delay_ff <= pwdata_i[CW-1:0];
        end else if (paddr_i == `TAM_ADDR_MODES) begin
          modes_ff <= pwdata_i[15:0];
        end else if (paddr_i == `TAM_ADDR_ASV1) begin
          asv_ff[0] <= pwdata_i[DW-1:0];
        end else if (paddr_i == `TAM_ADDR_ASV2) begin
          asv_ff[1] <= pwdata_i[DW-1:0];
        end else if (paddr_i == `TAM_ADDR_ASV3) begin
          asv_ff[2] <= pwdata_i[DW-1:0];
        end else if (paddr_i == `TAM_ADDR_ASV4) begin
          asv_ff[3] <= pwdata_i[DW-1:0];
        end else if (paddr_i == `TAM_ADDR_LBTIME) begin
          lb_time_ff <= pwdata_i[TW-1:0];
        end else if (paddr_i == `TAM_ADDR_SPAN) begin
          span_ff <= pwdata_i[DW-1:0];
        end
      end
    end
  end
endmodule
`default_nettype wire

/* rtl/tam_consts.vh */
// Constants for the temperature alert and loop break monitor
`ifndef TAM_CONSTS_VH
`define TAM_CONSTS_VH

// APB byte addresses
`define TAM_ADDR_CMD 12'h000
`define TAM_ADDR_CFG 12'h004
`define TAM_ADDR_SETV 12'h008
`define TAM_ADDR_DBAND 12'h00c
`define TAM_ADDR_DELAY 12'h010
`define TAM_ADDR_MODES 12'h014
`define TAM_ADDR_ASV1 12'h018
`define TAM_ADDR_ASV2 12'h01c
`define TAM_ADDR_ASV3 12'h020
`define TAM_ADDR_ASV4 12'h024
`define TAM_ADDR_LBTIME 12'h028
`define TAM_ADDR_SPAN 12'h02c
`define TAM_ADDR_STATUS 12'h030
`define TAM_ADDR_WSP 12'h034
`define TAM_ADDR_PV 12'h038

// Command word bits
`define TAM_CMD_OPMODE 1

// Configuration bits
`define TAM_CFG_REVERSE 0
`define TAM_CFG_LIMITER 1
`define TAM_CFG_CASCADE 2
`define TAM_CFG_AUTOTUNE 3
`define TAM_CFG_HEATCOOL 4
`define TAM_CFG_INTTEMP 5
`define TAM_CFG_W 6
`define TAM_CFG_RST 6'h21

// Status word bits
`define TAM_ST_ALERT_LO 8
`define TAM_ST_LOOP 13

// Alert mode codes
`define TAM_M_NONE 4'h0
`define TAM_M_UPIN 4'h1
`define TAM_M_LOIN 4'h2
`define TAM_M_UPDEV 4'h3
`define TAM_M_LODEV 4'h4
`define TAM_M_ULDEV 4'h5
`define TAM_M_RANGE 4'h6
`define TAM_M_WAIT_LO 4'h7
`define TAM_M_WAIT_HI 4'hb
`define TAM_M_REWAIT_LO 4'hc
`define TAM_M_REWAIT_HI 4'he
`define TAM_M_WAIT_OFS 4'h6
`define TAM_M_REWAIT_OFS 4'h9

// Loop break judgment width: 2.0 degC in 0.1 degC units, or 0.2 % of span
`define TAM_LB_WIDTH_TEMP 20
`define TAM_LB_SPAN_NUM 2
`define TAM_LB_SPAN_DEN 1000

// Sampling divider default, in clock cycles
`define TAM_SAMPLE_DIV 1000

`endif

/* rtl/tam_alert_unit.v */
// One alert evaluator: mode decode, hysteresis, delay count, wait and re-wait
`timescale 1ns/100ps
`default_nettype none
`include "tam_consts.vh"
module tam_alert_unit #(
  parameter DW = 16,
  parameter CW = 8
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire sample_i,
  input wire op_mode_i,
  input wire op_rise_i,
  input wire sv_change_i,
  input wire rewait_ok_i,
  input wire [3:0] mode_i,
  input wire signed [DW+1:0] pv_i,
  input wire signed [DW+1:0] dev_i,
  input wire signed [DW+1:0] asv_i,
  input wire signed [DW+1:0] dband_i,
  input wire [CW-1:0] delay_i,
  output wire alert_o
);
  reg alert_ff;
  reg wait_ff;
  reg seen_ok_ff;
  reg [CW-1:0] cnt_ff;
  reg [3:0] base;
  reg is_wait;
  reg is_rewait;
  reg on_c;
  reg stay_c;
  wire cond;
  wire cnt_full;

  // Fold wait and re-wait codes onto their plain alert type
  always @* begin
    base = mode_i;
    is_wait = 1'b0;
    is_rewait = 1'b0;
    if (mode_i >= `TAM_M_WAIT_LO && mode_i <= `TAM_M_WAIT_HI) begin
      base = mode_i - `TAM_M_WAIT_OFS;
      is_wait = 1'b1;
    end else if (mode_i >= `TAM_M_REWAIT_LO && mode_i <= `TAM_M_REWAIT_HI) begin
      base = mode_i - `TAM_M_REWAIT_OFS;
      is_wait = 1'b1;
      is_rewait = 1'b1;
    end
  end

  // Entry condition and the widened hold condition of the dead band
  always @* begin
    on_c = 1'b0;
    stay_c = 1'b0;
    case (base)
      `TAM_M_UPIN: begin
        on_c = pv_i >= asv_i;
        stay_c = pv_i > asv_i - dband_i;
      end
      `TAM_M_LOIN: begin
        on_c = pv_i <= asv_i;
        stay_c = pv_i < asv_i + dband_i;
      end
      `TAM_M_UPDEV: begin
        on_c = dev_i >= asv_i;
        stay_c = dev_i > asv_i - dband_i;
      end
      `TAM_M_LODEV: begin
        on_c = dev_i <= asv_i;
        stay_c = dev_i < asv_i + dband_i;
      end
      `TAM_M_ULDEV: begin
        on_c = (dev_i >= asv_i) || (dev_i <= -asv_i);
        stay_c = (dev_i > asv_i - dband_i) || (dev_i < dband_i - asv_i);
      end
      `TAM_M_RANGE: begin
        on_c = (dev_i >= -asv_i) && (dev_i <= asv_i);
        stay_c = (dev_i > -asv_i - dband_i) && (dev_i < asv_i + dband_i);
      end
      default: begin
        on_c = 1'b0;
        stay_c = 1'b0;
      end
    endcase
  end

  // Dead band applies to every alert type
  assign cond = on_c | (alert_ff & stay_c);
  assign cnt_full = cnt_ff >= delay_i;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alert_ff <= 1'b0;
      wait_ff <= 1'b0;
      seen_ok_ff <= 1'b0;
      cnt_ff <= {CW{1'b0}};
    end else if (!op_mode_i || base == `TAM_M_NONE) begin
      alert_ff <= 1'b0;
      cnt_ff <= {CW{1'b0}};
      // A non-alert judgment once seen keeps the operation-start wait off for good
      wait_ff <= op_rise_i & is_wait & ~seen_ok_ff;
    end else begin
      if (op_rise_i && is_wait && !seen_ok_ff) begin
        wait_ff <= 1'b1;
      end else if (sv_change_i && is_rewait && rewait_ok_i) begin
        wait_ff <= 1'b1;
      end else if (sample_i && !cond) begin
        wait_ff <= 1'b0;
      end
      if (sample_i) begin
        if (!cond) begin
          seen_ok_ff <= 1'b1;
          cnt_ff <= {CW{1'b0}};
          alert_ff <= 1'b0;
        end else begin
          if (!cnt_full) begin
            cnt_ff <= cnt_ff + {{(CW-1){1'b0}}, 1'b1};
          end
          // More consecutive samples than the delay count
          alert_ff <= cnt_full & ~wait_ff;
        end
      end
    end
  end

  assign alert_o = alert_ff;
endmodule
`default_nettype wire

/* dv/tam_plant_model.sv */
// Behavioural plant: process value ramp, set value monitor, output saturation
`timescale 1ns/100ps
`default_nettype none
module tam_plant_model (
  input wire logic clk_i,
  input wire logic load_i,
  input wire logic signed [15:0] pv_init_i,
  input wire logic signed [15:0] wsp_i,
  input wire logic signed [7:0] slope_i,
  input wire logic sat_lo_i,
  input wire logic sat_hi_i,
  output logic signed [15:0] process_value_o = 16'h0000,
  output logic signed [15:0] working_setpoint_o = 16'h0000,
  output logic out_at_low_o = 1'b0,
  output logic out_at_high_o = 1'b0
);
  // Value drifts by the slope each clock; load jumps it
  always @(posedge clk_i) begin
    if (load_i) begin
      process_value_o <= pv_init_i;
      working_setpoint_o <= wsp_i;
    end else begin
      process_value_o <= process_value_o + 16'(slope_i);
    end
    out_at_low_o <= sat_lo_i;
    out_at_high_o <= sat_hi_i;
  end
endmodule
`default_nettype wire

/* dv/tam_monitor_asserts.sv */
// Port checks for the alert and loop break monitor
`timescale 1ns/100ps
`default_nettype none
`include "tam_consts.vh"
module tam_monitor_asserts #(
  parameter DW = 16,
  parameter CW = 8,
  parameter TW = 16,
  parameter SAMPLE_DIV = 4
) (
  input wire clk_i,
  input wire rstn_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire signed [DW-1:0] process_value_i,
  input wire signed [DW-1:0] working_setpoint_i,
  input wire out_at_low_i,
  input wire out_at_high_i,
  input wire [3:0] alert_o,
  input wire loop_alert_o
);
  logic [5:0] cfg_ff;
  logic [3:0] mode1_ff;
  logic op_ff;
  logic lbt_zero_ff;
  wire setup = psel_i && !penable_i;
  wire wr_done = psel_i && penable_i && pwrite_i && pready_o;
  // Shadow of the settings the checks depend on
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_ff <= 6'h21;
      mode1_ff <= 4'h0;
      op_ff <= 1'b0;
      lbt_zero_ff <= 1'b1;
    end else if (wr_done) begin
      if (paddr_i == `TAM_ADDR_CFG) cfg_ff <= pwdata_i[5:0];
      if (paddr_i == `TAM_ADDR_MODES) mode1_ff <= pwdata_i[3:0];
      if (paddr_i == `TAM_ADDR_CMD) op_ff <= pwdata_i[1];
      if (paddr_i == `TAM_ADDR_LBTIME) lbt_zero_ff <= (pwdata_i[15:0] == 16'h0000);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_READY_AFTER_SETUP: assert property (setup |=> pready_o) else $error("no ready after setup");
  AST_READY_ONLY_ACCESS: assert property (pready_o |-> psel_i && penable_i && $past(setup))
    else $error("ready outside access");
  AST_ERR_UNMAPPED: assert property (setup && paddr_i > `TAM_ADDR_PV |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  AST_ERR_READ_ONLY: assert property (setup && pwrite_i && paddr_i >= `TAM_ADDR_STATUS |=> pslverr_o)
    else $error("read-only write not refused");
  AST_STATUS_MIRROR: assert property (
    pready_o && !pwrite_i && paddr_i == `TAM_ADDR_STATUS |-> prdata_o[11:8] == $past(alert_o)
    && prdata_o[13] == $past(loop_alert_o)) else $error("status bits differ from outputs");
  AST_IDLE_SILENT: assert property (!op_ff [*3] |-> alert_o == 4'h0 && !loop_alert_o)
    else $error("alert in setting mode");
  AST_MODE_NONE: assert property (mode1_ff == 4'h0 [*3] |-> !alert_o[0]) else $error("alert with mode none");
  AST_LB_OFF: assert property (lbt_zero_ff [*3] |-> !loop_alert_o) else $error("loop alert with zero time");
  AST_AT_OFF: assert property (cfg_ff[3] [*3] |-> !loop_alert_o) else $error("loop alert in tuning");
  AST_HC_OFF: assert property (cfg_ff[4] [*3] |-> !loop_alert_o) else $error("loop alert in heat-cool");
  AST_LOOP_SAT: assert property ((!out_at_low_i && !out_at_high_i) [*5] |-> !loop_alert_o)
    else $error("loop alert without saturation");
  cover property ($rose(alert_o[0]));
  cover property ($rose(loop_alert_o));
  cover property (pslverr_o);
endmodule
bind tam_monitor tam_monitor_asserts #(.DW(DW), .CW(CW), .TW(TW), .SAMPLE_DIV(SAMPLE_DIV)) tam_monitor_asserts_i (
  .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .process_value_i(process_value_i), .working_setpoint_i(working_setpoint_i), .out_at_low_i(out_at_low_i),
  .out_at_high_i(out_at_high_i), .alert_o(alert_o), .loop_alert_o(loop_alert_o));
`default_nettype wire

/* dv/tam_monitor_tb.sv */
// Self-checking bench for the alert and loop break monitor
`timescale 1ns/100ps
`default_nettype none
`include "tam_consts.vh"
module tam_monitor_tb;
  logic clk_i = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, load = 1, lo = 0, hi = 0, e, lbv;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [3:0] alv;
  logic signed [15:0] pvi = 500, wspi = 400;
  logic signed [7:0] slope = 0;
  wire [31:0] prdata;
  wire pready, pslverr, lb, olo, ohi;
  wire [3:0] al;
  wire signed [15:0] pv, wsp;
  int failures = 0, comparisons = 0;
  int av[8] = '{500, 499, 100, 99, 100, 100, 99, 0};
  int cf[9] = '{'h21, 'h21, 'h21, 'h21, 'h20, 'h20, 'h21, 'h29, 'h31};
  int lt[9] = '{3, 3, 3, 3, 3, 3, 0, 3, 3};
  int sh[9] = '{1, 1, 0, 0, 1, 0, 1, 1, 1};
  int sl[9] = '{0, 3, -3, -1, -3, 0, 0, 0, 0};
  int le[9] = '{1, 0, 0, 1, 0, 1, 0, 0, 0};
  tam_plant_model tam_plant_model_i (.clk_i(clk_i), .load_i(load), .pv_init_i(pvi), .wsp_i(wspi), .slope_i(slope),
    .sat_lo_i(lo), .sat_hi_i(hi), .process_value_o(pv), .working_setpoint_o(wsp), .out_at_low_o(olo),
    .out_at_high_o(ohi));
  tam_monitor #(.SAMPLE_DIV(4)) tam_monitor_i (.clk_i(clk_i), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .process_value_i(pv), .working_setpoint_i(wsp), .out_at_low_i(olo),
    .out_at_high_i(ohi), .alert_o(al), .loop_alert_o(lb));
  initial forever #25 clk_i = ~clk_i;
  task final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string w, input logic [31:0] x, input logic [31:0] g);
    comparisons++;
    if (g !== x) begin
      failures++;
      $display("mismatch %s expected %h seen %h", w, x, g);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One transfer; ready and data are taken at the rising edge that ends it
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) failures++;
    psel <= 0;
    penable <= 0;
    @(posedge clk_i);
  endtask
  task look;
    @(negedge clk_i);
    alv = al;
    lbv = lb;
    @(posedge clk_i);
  endtask
  task st(input logic [3:0] x);
    look;
    chk("alert_o", x, alv);
    apb(0, `TAM_ADDR_STATUS, 0);
    chk("status", x, q[11:8]);
  endtask
  task rst;
    rstn <= 0;
    wt(12);
    rstn <= 1;
    wt(3);
  endtask
  task plant(input int p, input int w);
    pvi <= p;
    wspi <= w;
    load <= 1;
    @(posedge clk_i);
    load <= 0;
  endtask
  task asv(input int i, input int v);
    apb(1, 12'(`TAM_ADDR_ASV1 + 4 * i), v & 32'hffff);
  endtask
  task op(input logic on);
    apb(1, `TAM_ADDR_CMD, {30'h0, on, 1'b0});
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    $display("timeout");
    final_report;
  end
  initial begin
    rst;
    apb(0, `TAM_ADDR_CFG, 0);
    chk("cfg reset", 32'h21, q);
    apb(0, 12'h03c, 0);
    chk("unmapped err", 1, e);
    apb(1, `TAM_ADDR_STATUS, 32'hf00);
    chk("read-only err", 1, e);
    plant(500, 400);
    for (int r = 0; r < 2; r++) begin
      apb(1, `TAM_ADDR_MODES, r ? 32'h0665 : 32'h4321);
      for (int i = 0; i < 4; i++) asv(i, av[r * 4 + i]);
      op(1);
      wt(20);
      st(r ? 4'b0011 : 4'b0101);
      op(0);
    end
    $display("plain modes done");
    rst;
    plant(500, 400);
    apb(1, `TAM_ADDR_MODES, 32'h8b97);
    for (int i = 0; i < 4; i++) asv(i, i == 0 ? 500 : (i == 3 ? 600 : 100));
    op(1);
    wt(20);
    st(4'b0000);
    plant(450, 400);
    wt(20);
    plant(500, 400);
    wt(20);
    st(4'b0111);
    op(0);
    op(1);
    wt(20);
    st(4'b0111);
    $display("wait done");
    rst;
    plant(500, 500);
    apb(1, `TAM_ADDR_MODES, 32'hadec);
    for (int i = 0; i < 4; i++) asv(i, i[0] ? -50 : 50);
    op(1);
    wt(20);
    st(4'b0000);
    apb(1, `TAM_ADDR_SETV, 600);
    plant(500, 600);
    wt(20);
    st(4'b1000);
    plant(500, 500);
    wt(20);
    apb(1, `TAM_ADDR_CFG, 32'h23);
    apb(1, `TAM_ADDR_SETV, 400);
    plant(500, 400);
    wt(20);
    st(4'b0001);
    $display("re-wait done");
    rst;
    plant(500, 400);
    apb(1, `TAM_ADDR_MODES, 1);
    asv(0, 500);
    apb(1, `TAM_ADDR_DBAND, 20);
    apb(1, `TAM_ADDR_DELAY, 5);
    op(1);
    wt(16);
    st(4'b0000);
    wt(10);
    st(4'b0001);
    plant(490, 400);
    wt(20);
    st(4'b0001);
    plant(480, 400);
    wt(20);
    st(4'b0000);
    op(0);
    $display("band and delay done");
    for (int i = 0; i < 9; i++) begin
      plant(500, 500);
      apb(1, `TAM_ADDR_CFG, cf[i]);
      apb(1, `TAM_ADDR_LBTIME, lt[i]);
      op(1);
      slope <= 8'(sl[i]);
      hi <= sh[i][0];
      lo <= !sh[i][0];
      wt(60);
      look;
      chk("loop_alert_o", le[i], lbv);
      apb(0, `TAM_ADDR_STATUS, 0);
      chk("status loop", le[i], q[13]);
      hi <= 0;
      lo <= 0;
      slope <= 0;
      op(0);
    end
    $display("loop break done");
    final_report;
  end
endmodule
`default_nettype wire
